// [verilog/dma_pkg.sv]
// constants and types shared by the two-channel dma block
// assumes a single 25 MHz system clock domain
package dma_pkg;
   // ***********************
   // widths
   // ***********************
   localparam int ADDR_W = 20;
   localparam int CTRL_W = 11;

   // ***********************
   // register map, per channel
   // ***********************
   localparam logic [7:0] OFF_SRC_LO = 8'h00;
   localparam logic [7:0] OFF_SRC_HI = 8'h04;
   localparam logic [7:0] OFF_DST_LO = 8'h08;
   localparam logic [7:0] OFF_DST_HI = 8'h0C;
   localparam logic [7:0] OFF_CTRL   = 8'h10;
   localparam logic [7:0] OFF_STAT   = 8'h14;
   localparam logic [7:0] OFF_MASK   = 8'h1F;

   // ***********************
   // control fields
   // ***********************
   localparam int CTL_DEST_SPACE = 0;
   localparam int CTL_DEST_DEC   = 1;
   localparam int CTL_DEST_INC   = 2;
   localparam int CTL_SRC_SPACE  = 3;
   localparam int CTL_SRC_DEC    = 4;
   localparam int CTL_SRC_INC    = 5;
   localparam int CTL_WORD       = 6;
   localparam int CTL_PRIO       = 7;
   localparam int CTL_SYNC_LO    = 8;
   localparam int CTL_SYNC_HI    = 9;
   localparam int CTL_ARM        = 10;
   localparam int STAT_REQ       = 0;
   localparam int STAT_BUSY      = 1;
   localparam int STAT_FAVORED   = 2;

   localparam logic [1:0] SYNC_NONE = 2'h0;
   localparam logic [1:0] SYNC_DEST = 2'h2;

   // ***********************
   // reset values and steps
   // ***********************
   localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
   localparam logic [ADDR_W-1:0] PTR_RESET  = 20'h00000;
   localparam logic [ADDR_W-1:0] STEP_BYTE  = 20'h00001;
   localparam logic [ADDR_W-1:0] STEP_WORD  = 20'h00002;
   localparam logic              ROT_RESET  = 1'b1;

   typedef enum logic [2:0] {
      XF_IDLE, XF_FETCH, XF_DEPOSIT, XF_IDLE1, XF_IDLE2
   } xfer_type;

   function automatic logic [ADDR_W-1:0] step_size(input logic word);
      return word ? STEP_WORD : STEP_BYTE;
   endfunction
endpackage

// [verilog/dma_pointer.sv]
// one 20-bit source or destination pointer with indexing
// assumes loads and steps come from logic on ref_clk
`timescale 1ns/1ps
module dma_pointer (
   // system
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   // software load
   input  wire logic                      loadLow,
   input  wire logic                      loadHigh,
   input  wire logic [15:0]               loadData,
   // indexing
   input  wire logic                      step,
   input  wire logic                      stepUp,
   input  wire logic                      stepDown,
   input  wire logic                      wordSize,
   output logic      [dma_pkg::ADDR_W-1:0] ptr
);
   import dma_pkg::*;

   typedef struct packed {
      logic [ADDR_W-1:0] value;
   } ptr_state_type;

   ptr_state_type s;
   ptr_state_type next_s;

   always_comb begin
      next_s = s;
      // full-width add so carries reach the top nibble
      if (step && stepUp && !stepDown) begin
         next_s.value = s.value + step_size(wordSize);
      end else if (step && stepDown && !stepUp) begin
         next_s.value = s.value - step_size(wordSize);
      end
      // a software write wins over a step in the same cycle
      if (loadLow) begin
         next_s.value[15:0] = loadData;
      end
      if (loadHigh) begin
         next_s.value[19:16] = loadData[3:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s.value <= PTR_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign ptr = s.value;

   property p_step_up;
      @(posedge ref_clk) disable iff (!rst_n)
      step && stepUp && !stepDown && !loadLow && !loadHigh
      |=> ptr == $past(ptr) + (($past(wordSize)) ? STEP_WORD : STEP_BYTE);
   endproperty
   a_step_up: assert property (p_step_up)
      else $error("pointer did not advance by the data width");

   property p_step_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      step && (stepUp == stepDown) && !loadLow && !loadHigh |=> $stable(ptr);
   endproperty
   a_step_hold: assert property (p_step_hold)
      else $error("pointer moved with equal index bits");
endmodule // dma_pointer

// [verilog/dma_arbiter.sv]
// channel arbiter: fixed or rotating priority between two channels
// assumes it is consulted only at transfer boundaries
`timescale 1ns/1ps
module dma_arbiter (
   // system
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // requests and priority bits
   input  wire logic [1:0] req,
   input  wire logic [1:0] highPrio,
   // completed transfer
   input  wire logic       doneStrobe,
   input  wire logic       doneCh,
   input  wire logic       doneReleased,
   // decision
   output logic            grantValid,
   output logic            grantCh,
   output logic            rotTop
);
   import dma_pkg::*;

   typedef struct packed {
      logic rotTop;
      logic relLast;
      logic relCh;
   } arb_state_type;

   arb_state_type s;
   arb_state_type next_s;
   logic          fixedMode;
   logic          hiCh;

   always_comb begin
      fixedMode  = highPrio[0] != highPrio[1];
      hiCh       = highPrio[1];
      grantValid = req != 2'h0;
      grantCh    = req[1];
      if (req == 2'h3) begin
         if (fixedMode) begin
            // a released high channel lends one slot to the low one
            if (s.relLast && s.relCh == hiCh) begin
               grantCh = ~hiCh;
            end else begin
               grantCh = hiCh;
            end
         end else begin
            grantCh = s.rotTop;
         end
      end
      next_s = s;
      if (doneStrobe) begin
         next_s.relLast = doneReleased;
         next_s.relCh   = doneCh;
         next_s.rotTop  = doneReleased ? ROT_RESET : ~doneCh;
      end
      if (req == 2'h0) begin
         next_s.rotTop = ROT_RESET;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s.rotTop  <= ROT_RESET;
         s.relLast <= 1'b0;
         s.relCh   <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign rotTop = s.rotTop;

   property p_fixed_first;
      @(posedge ref_clk) disable iff (!rst_n)
      req == 2'h3 && highPrio[0] != highPrio[1] && !s.relLast
      |-> grantValid && grantCh == highPrio[1];
   endproperty
   a_fixed_first: assert property (p_fixed_first)
      else $error("low channel granted over high channel");

   property p_rotate_grant;
      @(posedge ref_clk) disable iff (!rst_n)
      req == 2'h3 && highPrio[0] == highPrio[1] |-> grantCh == s.rotTop;
   endproperty
   a_rotate_grant: assert property (p_rotate_grant)
      else $error("rotating grant ignores favored channel");

   property p_rotate_after;
      @(posedge ref_clk) disable iff (!rst_n)
      doneStrobe && !doneReleased && req != 2'h0 |=> rotTop == !$past(doneCh);
   endproperty
   a_rotate_after: assert property (p_rotate_after)
      else $error("serviced channel kept high rotating priority");

   property p_release_top;
      @(posedge ref_clk) disable iff (!rst_n)
      (doneStrobe && doneReleased) || req == 2'h0 |=> rotTop;
   endproperty
   a_release_top: assert property (p_release_top)
      else $error("channel 1 not restored after bus release");
endmodule // dma_arbiter

// [verilog/dma_channel_priority_and_pointers.sv]
// two-channel dma: register file, transfer sequencer, pointers
// assumes a classic wishbone master and a bus unit that pulses
// busDone once per finished fetch or deposit cycle
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

// Contract
// - both request, high-priority channel goes first
// - high channel continues while requesting, armed, unreleased
// - released destination-sync high lends one transfer
// - mixed synchronization alternates while both request
// - higher channel preempts lower at next boundary
// - equal priority bits select rotating priority
// - rotation starts with channel 1 favored
// - serviced channel drops to lower rotating priority
// - channel 1 favored again on bus release
// - six software registers per channel
// - pointers are 20 bits from two registers
// - upper pointer bits driven even for I/O
// - source low bits address the fetch
// - destination upper bits drive address 19:16
// - destination low bits address the deposit
// - separate space select per pointer
// - pointer steps by inc/dec, equal holds
// - step size follows channel data width
// - word steps two, byte steps one
// - destination sync adds two released idle states
// - priority bit set means high priority
// - space bit set memory, clear I/O
module dma_channel_priority_and_pointers (
   // system
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   // wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [7:0]                 wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   // request pins and global hold-off
   input  wire logic [1:0]                 dmaRequestPin,
   input  wire logic                       suspend,
   // bus interface unit side
   output logic                            busReq,
   output logic      [dma_pkg::ADDR_W-1:0] busAddr,
   output logic                            busMemSpace,
   output logic                            busWrite,
   output logic                            busWord,
   output logic                            busChannel,
   input  wire logic                       busDone
);
   import dma_pkg::*;

   // ***********************
   // state
   // ***********************
   typedef struct packed {
      logic [1:0]                   reqMeta;
      logic [1:0]                   reqSync;
      logic                         ack;
      logic [31:0]                  rdData;
      logic [1:0][CTRL_W-1:0]       ctrl;
      xfer_type                     st;
      logic                         ch;
      logic [ADDR_W-1:0]            addr;
      logic                         mem;
      logic                         write;
      logic                         word;
   } main_state_type;

   main_state_type s;
   main_state_type next_s;

   logic [1:0][ADDR_W-1:0] srcPtr;
   logic [1:0][ADDR_W-1:0] dstPtr;
   logic [1:0]             srcLoadLo;
   logic [1:0]             srcLoadHi;
   logic [1:0]             dstLoadLo;
   logic [1:0]             dstLoadHi;
   logic [15:0]            loadData;
   logic [1:0]             stepCh;
   logic [1:0]             reqVec;
   logic [1:0]             highPrio;
   logic [7:0]             off;
   logic                   wch;
   logic                   mapped;
   logic                   wrEn;
   logic                   depositDone;
   logic                   grantValid;
   logic                   grantCh;
   logic                   rotTop;
   logic [31:0]            rdWord;
   logic [15:0]            oldHalf;

   // ***********************
   // helpers
   // ***********************
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0]  sel
   );
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   function automatic logic is_dest_sync(input logic [CTRL_W-1:0] c);
      return c[CTL_SYNC_HI:CTL_SYNC_LO] == SYNC_DEST;
   endfunction

   // ***********************
   // request qualification
   // ***********************
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         // unsynchronized channels request for as long as they are armed and suspend is low
         reqVec[c] = s.ctrl[c][CTL_ARM] && !suspend &&
                     (s.ctrl[c][CTL_SYNC_HI:CTL_SYNC_LO] == SYNC_NONE ||
                      s.reqSync[c]);
         highPrio[c] = s.ctrl[c][CTL_PRIO];
      end
   end

   // ***********************
   // register file and sequencer
   // ***********************
   always_comb begin
      next_s         = s;
      next_s.reqMeta = dmaRequestPin;
      next_s.reqSync = s.reqMeta;

      off    = wb_adr_i & OFF_MASK;
      wch    = wb_adr_i[5];
      // 0x18..0x1F of each channel and anything above 0x3F is unmapped
      mapped = wb_adr_i[7:6] == 2'h0 && wb_adr_i[1:0] == 2'h0 &&
               off <= OFF_STAT;
      wrEn   = wb_cyc_i && wb_stb_i && wb_we_i && s.ack && mapped;
      next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;

      rdWord = 32'h0000_0000;
      if (mapped) begin
         unique case (off)
            OFF_SRC_LO: rdWord[15:0] = srcPtr[wch][15:0];
            OFF_SRC_HI: rdWord[3:0]  = srcPtr[wch][19:16];
            OFF_DST_LO: rdWord[15:0] = dstPtr[wch][15:0];
            OFF_DST_HI: rdWord[3:0]  = dstPtr[wch][19:16];
            OFF_CTRL:   rdWord[CTRL_W-1:0] = s.ctrl[wch];
            OFF_STAT: begin
               rdWord[STAT_REQ]     = reqVec[wch];
               rdWord[STAT_BUSY]    = s.st != XF_IDLE && s.ch == wch;
               rdWord[STAT_FAVORED] = rotTop == wch;
            end
            default: rdWord = 32'h0000_0000;
         endcase
      end
      if (wb_cyc_i && wb_stb_i && !s.ack) begin
         next_s.rdData = rdWord;
      end

      srcLoadLo = 2'h0;
      srcLoadHi = 2'h0;
      dstLoadLo = 2'h0;
      dstLoadHi = 2'h0;
      oldHalf   = 16'h0000;
      unique case (off)
         OFF_SRC_LO: oldHalf = srcPtr[wch][15:0];
         OFF_SRC_HI: oldHalf = {12'h000, srcPtr[wch][19:16]};
         OFF_DST_LO: oldHalf = dstPtr[wch][15:0];
         OFF_DST_HI: oldHalf = {12'h000, dstPtr[wch][19:16]};
         OFF_CTRL:   oldHalf = {5'h00, s.ctrl[wch]};
         default:    oldHalf = 16'h0000;
      endcase
      loadData = merge16(oldHalf, wb_dat_i, wb_sel_i);
      if (wrEn) begin
         unique case (off)
            OFF_SRC_LO: srcLoadLo[wch] = 1'b1;
            OFF_SRC_HI: srcLoadHi[wch] = 1'b1;
            OFF_DST_LO: dstLoadLo[wch] = 1'b1;
            OFF_DST_HI: dstLoadHi[wch] = 1'b1;
            OFF_CTRL:   next_s.ctrl[wch] = loadData[CTRL_W-1:0];
            default: begin
            end
         endcase
      end

      depositDone = 1'b0;
      stepCh      = 2'h0;
      unique case (s.st)
         XF_IDLE: begin
            // the arbiter is heard only here, between transfers
            if (grantValid) begin
               next_s.st    = XF_FETCH;
               next_s.ch    = grantCh;
               next_s.addr  = srcPtr[grantCh];
               next_s.mem   = s.ctrl[grantCh][CTL_SRC_SPACE];
               next_s.write = 1'b0;
               next_s.word  = s.ctrl[grantCh][CTL_WORD];
            end
         end
         XF_FETCH: begin
            if (busDone) begin
               next_s.st    = XF_DEPOSIT;
               next_s.addr  = dstPtr[s.ch];
               next_s.mem   = s.ctrl[s.ch][CTL_DEST_SPACE];
               next_s.write = 1'b1;
            end
         end
         XF_DEPOSIT: begin
            if (busDone) begin
               depositDone    = 1'b1;
               stepCh[s.ch]   = 1'b1;
               next_s.write   = 1'b0;
               // idle states hand the bus back to other masters
               next_s.st = is_dest_sync(s.ctrl[s.ch]) ? XF_IDLE1 : XF_IDLE;
            end
         end
         XF_IDLE1: next_s.st = XF_IDLE2;
         XF_IDLE2: next_s.st = XF_IDLE;
         default:  next_s.st = XF_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s.reqMeta <= 2'h0;
         s.reqSync <= 2'h0;
         s.ack     <= 1'b0;
         s.rdData  <= 32'h0000_0000;
         s.ctrl    <= {CTRL_RESET, CTRL_RESET};
         s.st      <= XF_IDLE;
         s.ch      <= 1'b0;
         s.addr    <= PTR_RESET;
         s.mem     <= 1'b0;
         s.write   <= 1'b0;
         s.word    <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // ***********************
   // pointers and arbiter
   // ***********************
   for (genvar c = 0; c < 2; c++) begin : g_chan
      dma_pointer u_src (
         .ref_clk  (ref_clk),
         .rst_n    (rst_n),
         .loadLow  (srcLoadLo[c]),
         .loadHigh (srcLoadHi[c]),
         .loadData (loadData),
         .step     (stepCh[c]),
         .stepUp   (s.ctrl[c][CTL_SRC_INC]),
         .stepDown (s.ctrl[c][CTL_SRC_DEC]),
         .wordSize (s.ctrl[c][CTL_WORD]),
         .ptr      (srcPtr[c])
      );
      dma_pointer u_dst (
         .ref_clk  (ref_clk),
         .rst_n    (rst_n),
         .loadLow  (dstLoadLo[c]),
         .loadHigh (dstLoadHi[c]),
         .loadData (loadData),
         .step     (stepCh[c]),
         .stepUp   (s.ctrl[c][CTL_DEST_INC]),
         .stepDown (s.ctrl[c][CTL_DEST_DEC]),
         .wordSize (s.ctrl[c][CTL_WORD]),
         .ptr      (dstPtr[c])
      );
   end

   dma_arbiter u_arb (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .req          (reqVec),
      .highPrio     (highPrio),
      .doneStrobe   (depositDone),
      .doneCh       (s.ch),
      .doneReleased (is_dest_sync(s.ctrl[s.ch])),
      .grantValid   (grantValid),
      .grantCh      (grantCh),
      .rotTop       (rotTop)
   );

   // ***********************
   // outputs
   // ***********************
   assign wb_ack_o    = s.ack;
   assign wb_dat_o    = s.rdData;
   assign busReq      = s.st == XF_FETCH || s.st == XF_DEPOSIT;
   assign busAddr     = s.addr;
   assign busMemSpace = s.mem;
   assign busWrite    = s.write;
   assign busWord     = s.word;
   assign busChannel  = s.ch;

   // ***********************
   // checks
   // ***********************
   property p_fetch_addr;
      @(posedge ref_clk) disable iff (!rst_n)
      s.st == XF_IDLE && grantValid
      |=> busReq && !busWrite && busAddr == $past(srcPtr[grantCh]);
   endproperty
   a_fetch_addr: assert property (p_fetch_addr)
      else $error("fetch address is not the source pointer");

   property p_deposit_addr;
      @(posedge ref_clk) disable iff (!rst_n)
      s.st == XF_FETCH && busDone
      |=> busWrite && busAddr[19:16] == $past(dstPtr[s.ch][19:16])
          && busAddr[15:0] == $past(dstPtr[s.ch][15:0]);
   endproperty
   a_deposit_addr: assert property (p_deposit_addr)
      else $error("deposit address is not the destination pointer");

   property p_space_sel;
      @(posedge ref_clk) disable iff (!rst_n)
      s.st == XF_FETCH && busDone
      |=> busMemSpace == $past(s.ctrl[s.ch][CTL_DEST_SPACE]);
   endproperty
   a_space_sel: assert property (p_space_sel)
      else $error("deposit space does not follow its select bit");

   property p_idle_gap;
      @(posedge ref_clk) disable iff (!rst_n)
      s.st == XF_DEPOSIT && busDone && is_dest_sync(s.ctrl[s.ch])
      |=> !busReq [*2] ##1 s.st == XF_IDLE;
   endproperty
   a_idle_gap: assert property (p_idle_gap)
      else $error("destination-sync transfer missed its two idle states");

   property p_whole_xfer;
      @(posedge ref_clk) disable iff (!rst_n)
      s.st == XF_FETCH
      |=> (s.st == XF_FETCH || s.st == XF_DEPOSIT) && $stable(busChannel);
   endproperty
   a_whole_xfer: assert property (p_whole_xfer)
      else $error("channel switched inside a transfer");

   property p_ack_once;
      @(posedge ref_clk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("wishbone ack held longer than one cycle");
endmodule // dma_channel_priority_and_pointers

// [tb/dma_bus_unit_model.sv]
// behavioural bus interface unit: finishes each dma phase after a delay
// assumes busReq stays high from fetch through deposit of one transfer
`timescale 1ns/1ps
module dma_bus_unit_model #(
   parameter int WAIT = 3
) (
   // system
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // dma side
   input  wire logic busReq,
   output logic      busDone
);
   int count;

   // counter restarts after each pulse so fetch and deposit each wait
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count   <= 0;
         busDone <= 1'b0;
      end else if (busReq && !busDone && count >= WAIT) begin
         count   <= 0;
         busDone <= 1'b1;
      end else begin
         count   <= (busReq && !busDone) ? count + 1 : 0;
         busDone <= 1'b0;
      end
   end
endmodule // dma_bus_unit_model

// [tb/dma_channel_priority_and_pointers_tb_top.sv]
// self-checking bench for the two-channel dma block
// assumes a 25 MHz clock and the bus unit model on the far side
`timescale 1ns/1ps
module dma_channel_priority_and_pointers_tb_top;
   import dma_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        wbCyc   = 1'b0;
   logic        wbStb   = 1'b0;
   logic        wbWe    = 1'b0;
   logic [7:0]  wbAdr   = 8'h00;
   logic [3:0]  wbSel   = 4'h0;
   logic [31:0] wbDat   = 32'h00000000;
   logic [1:0]  reqPin  = 2'h0;
   logic        suspend = 1'b0;
   logic [31:0] wbDatO;
   logic        wbAck, busReq, busMemSpace, busWrite, busWord, busChannel, busDone;
   logic [19:0] busAddr;
   int          err_count = 0;
   int          compares = 0;

   dma_channel_priority_and_pointers i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .dmaRequestPin(reqPin), .suspend(suspend), .busReq(busReq), .busAddr(busAddr),
      .busMemSpace(busMemSpace), .busWrite(busWrite), .busWord(busWord),
      .busChannel(busChannel), .busDone(busDone));
   dma_bus_unit_model i_bus (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
      .busDone(busDone));

   always #20 ref_clk = ~ref_clk;

   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // classic single cycle, held until ack is sampled at a rising edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge ref_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe  <= we;
      wbAdr <= a;
      wbDat <= d;
      wbSel <= 4'hF;
      // no limit here: a missing ack is left to the watchdog
      do begin
         @(posedge ref_clk);
      end while (wbAck !== 1'b1);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h00000000, q);
      chk(what, exp, q);
   endtask

   // waits for a fetch (wr 0) or deposit (wr 1) phase, bounded
   task automatic phase(input logic wr, output logic ch, output logic [19:0] a,
                        output logic mem);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!(busReq === 1'b1 && busWrite === wr) && n < 200);
      ch = busChannel;
      a = busAddr;
      mem = busMemSpace;
      if (n >= 200) chk("phase wait", 32'h1, 32'h0);
   endtask

   task automatic regs_check;
      logic [31:0] q;
      rd("control reset", 8'h10, 32'h00000000);
      wb(1'b1, 8'h20, 32'h0000A5C3, q);
      rd("source low", 8'h20, 32'h0000A5C3);
      wb(1'b1, 8'h18, 32'h0000FFFF, q);
      rd("unmapped", 8'h18, 32'h00000000);
   endtask

   task automatic pointer_xfer;
      logic [31:0] q;
      logic        ch, m;
      logic [19:0] a;
      wb(1'b1, 8'h00, 32'h0000FFFE, q);
      wb(1'b1, 8'h04, 32'h00000003, q);
      wb(1'b1, 8'h08, 32'h00000000, q);
      wb(1'b1, 8'h0C, 32'h00000005, q);
      // armed, request-pin sync (field 1, not destination), word, source up in memory, dest down in i/o
      wb(1'b1, 8'h10, 32'h0000056A, q);
      reqPin <= 2'b01;
      phase(1'b0, ch, a, m);
      reqPin <= 2'b00;
      chk("fetch address", 32'h0003FFFE, {12'h000, a});
      chk("fetch space", 32'h1, {31'h0, m});
      chk("word width", 32'h1, {31'h0, busWord});
      phase(1'b1, ch, a, m);
      chk("deposit address", 32'h00050000, {12'h000, a});
      chk("deposit space", 32'h0, {31'h0, m});
      repeat (12) @(posedge ref_clk);
      rd("source low after", 8'h00, 32'h00000000);
      rd("source high after", 8'h04, 32'h00000004);
      rd("dest low after", 8'h08, 32'h0000FFFE);
      rd("dest high after", 8'h0C, 32'h00000004);
      wb(1'b1, 8'h10, 32'h00000000, q);
   endtask

   task automatic fixed_prio;
      logic [31:0] q;
      logic        ch, m;
      logic [19:0] a;
      wb(1'b1, 8'h30, 32'h00000580, q);
      // low channel: byte wide, source steps up
      wb(1'b1, 8'h10, 32'h00000520, q);
      suspend <= 1'b1;
      reqPin  <= 2'b11;
      repeat (3) @(posedge ref_clk);
      rd("suspended status", 8'h14, 32'h00000000);
      suspend <= 1'b0;
      phase(1'b0, ch, a, m);
      reqPin <= 2'b01;
      chk("fixed first grant", 32'h1, {31'h0, ch});
      chk("byte width", 32'h0, {31'h0, busWord});
      phase(1'b1, ch, a, m);
      phase(1'b0, ch, a, m);
      reqPin <= 2'b11;
      chk("fixed second grant", 32'h0, {31'h0, ch});
      phase(1'b1, ch, a, m);
      phase(1'b0, ch, a, m);
      reqPin <= 2'b00;
      chk("preempting grant", 32'h1, {31'h0, ch});
      repeat (12) @(posedge ref_clk);
      // high channel on destination sync lends every other slot
      wb(1'b1, 8'h30, 32'h00000680, q);
      reqPin <= 2'b11;
      for (int i = 0; i < 4; i++) begin
         phase(1'b0, ch, a, m);
         if (i == 3) reqPin <= 2'b00;
         chk("mixed sync grant", (i % 2 == 0) ? 32'h1 : 32'h0, {31'h0, ch});
         phase(1'b1, ch, a, m);
      end
      repeat (12) @(posedge ref_clk);
      rd("byte steps", 8'h00, 32'h00000003);
   endtask

   // second round shows channel 1 favoured again after requests went away
   task automatic rotate;
      logic [31:0] q;
      logic        ch, m;
      logic [19:0] a;
      wb(1'b1, 8'h30, 32'h00000500, q);
      for (int r = 0; r < 2; r++) begin
         reqPin <= 2'b11;
         for (int i = 0; i < 3; i++) begin
            phase(1'b0, ch, a, m);
            if (i == 2) reqPin <= 2'b00;
            chk("rotating grant", (i % 2 == 0) ? 32'h1 : 32'h0, {31'h0, ch});
            phase(1'b1, ch, a, m);
         end
         repeat (12) @(posedge ref_clk);
      end
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      regs_check();
      pointer_xfer();
      fixed_prio();
      rotate();
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      complete_run();
   end
endmodule // dma_channel_priority_and_pointers_tb_top
